// [hw/dms_pkg.sv]
/*
  Shared constants and types of the dual multiply-subtract/accumulate
  datapath: register indices, field positions, opcode codes, saturation
  and rounding constants, and the structs that carry operands, addresses
  and results.
  Assumes a word-addressed register bus and 16-bit memory read buses.

  // How it works
  // (RULE1) Shared single-word form: fifth nibble 0001, sixth nibble upper bits 11.
  // (RULE2) Long-word form: fifth nibble 0101, sixth nibble upper bits 11.
  // (RULE3) One pass: upper unit subtracts from accum_y, lower unit adds to accum_x.
  // (RULE4) Single-word form: operand_d_bus word feeds both multipliers.
  // (RULE5) Upper coefficient read at coeff_pointer on coeff_high_bus, to upper unit.
  // (RULE6) Lower coefficient read at paired address (+1 even, -1 odd), coeff_low_bus.
  // (RULE7) Long form: high operand at effective location on operand_c_bus, upper unit.
  // (RULE8) Long form: low operand at paired address on operand_d_bus, lower unit.
  // (RULE9) Multiplier inputs widened to 17 bits: zero if unsigned, else sign.
  // (RULE10) Fractional mode shifts each product left by one.
  // (RULE11) Product saturate bit governs product overflow handling.
  // (RULE12) Upper 32-bit product sign-extended to 40 bits, subtracted from accum_y.
  // (RULE13) Lower 32-bit product sign-extended to 40 bits, added to accum_x.
  // (RULE14) Rounding qualifier rounds both results per rounding mode bit.
  // (RULE15) Overflow checked at width from wide mode bit; sets destination flag.
  // (RULE16) On overflow, saturate per accumulator saturate bit.
  // (RULE17) 40-bit qualifier forces wide mode for this instruction only.
  // (RULE18) Software keeps the coefficient operand in internal memory.
  // (RULE19) Both forms may run under the single-instruction repeat.
  // (RULE20) Coefficient pointer post-increment with half select adds 2.
  // (RULE21) Long form data pointer post-decrement with half select subtracts 2.
  // (RULE22) Single-word data pointer post-decrement subtracts 1.
  // (RULE23) Both accumulators and both flags commit in the same cycle.
*/

package dms_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register word indices
  localparam logic [3:0] REG_MODE = 4'h0;
  localparam logic [3:0] REG_INSTR = 4'h1;
  localparam logic [3:0] REG_REPEAT = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_CPTR = 4'h4;
  localparam logic [3:0] REG_APTR = 4'h5;
  localparam logic [3:0] REG_ACC_BASE = 4'h8;

  // Status bit positions; overflow flags sit in bits 3..0
  localparam int STAT_ILLEGAL = 4;
  localparam int STAT_BUSY = 8;
  localparam logic [4:0] STAT_W1C_MASK = 5'h1f;

  ////////////////////////////////////////////////////////////////////////////
  // Opcode codes
  localparam logic [7:0] OPC_HEAD = 8'hfd;
  localparam logic [3:0] NIB5_SHARED = 4'h1;
  localparam logic [3:0] NIB5_LONG = 4'h5;
  localparam logic [1:0] NIB6_TOP = 2'h3;
  localparam logic [1:0] PMOD_INC = 2'h1;
  localparam logic [1:0] PMOD_DEC = 2'h2;

  // Pointer steps
  localparam logic [15:0] STEP_WORD = 16'h0001;
  localparam logic [15:0] STEP_PAIR = 16'h0002;

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic constants
  localparam int NARROW_MSB = 31;
  localparam int RND_LSB = 16;
  localparam logic [16:0] PRODUCT_SATURATE_BIT_MIN17 = 17'h1_8000;
  localparam logic [31:0] PRODUCT_SATURATE_BIT_SAT = 32'h7fff_ffff;
  localparam logic [40:0] RND_HALF = 41'h000_0000_8000;
  localparam logic [40:0] RND_MASK = 41'h1ff_ffff_0000;
  localparam logic [15:0] RND_TIE = 16'h8000;
  localparam logic [39:0] SAT40_POS = 40'h7f_ffff_ffff;
  localparam logic [39:0] SAT40_NEG = 40'h80_0000_0000;
  localparam logic [39:0] SAT32_POS = 40'h00_7fff_ffff;
  localparam logic [39:0] SAT32_NEG = 40'hff_8000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_FETCH = 4'h2,
    S_MUL = 4'h4,
    S_COMMIT = 4'h8
  } dms_state_t;

  typedef struct packed {
    logic accum_saturate_bit;
    logic wide_overflow_mode_bit;
    logic rounding_mode_bit;
    logic product_saturate_bit;
    logic fractional_mode_bit;
  } dms_mode_t;

  typedef struct packed {
    logic long_form;
    logic [6:0] doff;
    logic indirect;
    logic [1:0] amod;
    logic [1:0] cmod;
    logic [1:0] accum_x;
    logic [1:0] accum_y;
    logic data_uns;
    logic coeff_uns;
    logic force40;
    logic round;
  } dms_instr_t;

  typedef struct packed {
    logic [15:0] operand_d_bus;
    logic [15:0] operand_c_bus;
    logic [15:0] coeff_low_bus;
    logic [15:0] coeff_high_bus;
  } dms_rdbus_t;

  typedef struct packed {
    logic [15:0] data_addr;
    logic [15:0] data_pair_addr;
    logic [15:0] coeff_address_bus;
    logic [15:0] coeff_pair_addr;
    logic data_rd;
    logic data_pair_rd;
    logic coeff_rd;
  } dms_addr_t;

  typedef struct packed {
    logic ovf;
    logic [39:0] value;
  } dms_res_t;

endpackage : dms_pkg

// [hw/dms_datapath.sv]
/*
  Dual multiply-subtract/accumulate datapath with Avalon-MM register
  slave, operand address generation, two 17x17 multipliers, rounding,
  overflow detection, saturation and pointer post-modification.
  Assumes synchronous memories on ref_clk that return read data one
  cycle after the read strobe, and a single-clock system.
*/
// Implementation choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none

module dms_datapath
  import dms_pkg::*;
#(
  parameter int REP_W = 8
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire dms_pkg::dms_rdbus_t rdbus,
  output dms_pkg::dms_addr_t mem_addr,
  output logic [3:0] ovf_flags
);
  import dms_pkg::*;

  // Repeat counter must fit the low half of the bus word
  if (REP_W < 1 || REP_W > 16) begin : g_bad_rep
    $error("REP_W must lie between 1 and 16");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Opcode acceptance for the two handled forms
  function automatic logic legal(input logic [31:0] w);
    return w[31:24] == OPC_HEAD && w[11:10] == NIB6_TOP &&
      (w[15:12] == NIB5_SHARED || w[15:12] == NIB5_LONG); // [RULE1] [RULE2]
  endfunction : legal

  function automatic dms_instr_t decode(input logic [31:0] w);
    dms_instr_t d;
    d.long_form = w[15:12] == NIB5_LONG; // [RULE2]
    d.doff = w[23:17];
    d.indirect = w[16];
    d.amod = w[18:17];
    d.cmod = w[9:8];
    d.accum_x = w[7:6];
    d.accum_y = w[5:4];
    d.data_uns = w[3];
    d.coeff_uns = w[2];
    d.force40 = w[1];
    d.round = w[0];
    return d;
  endfunction : decode

  // Partner word of a long pair: +1 when even, -1 when odd
  function automatic logic [15:0] pair(input logic [15:0] a);
    return a[0] ? a - STEP_WORD : a + STEP_WORD; // [RULE6] [RULE8]
  endfunction : pair

  function automatic logic [16:0] ext17(input logic [15:0] v, input logic u);
    return u ? {1'b0, v} : {v[15], v}; // [RULE9]
  endfunction : ext17

  function automatic logic [31:0] mult(input logic [16:0] a,
                                       input logic [16:0] b,
                                       input dms_mode_t m);
    logic signed [33:0] p;
    p = $signed(a) * $signed(b);
    if (m.fractional_mode_bit)
    begin
      p = p <<< 1; // [RULE10]
    end
    // For signed operands only the fractional min-times-min case can pass 32 bits
    if (m.product_saturate_bit && m.fractional_mode_bit &&
        a == PRODUCT_SATURATE_BIT_MIN17 && b == PRODUCT_SATURATE_BIT_MIN17)
    begin
      return PRODUCT_SATURATE_BIT_SAT; // [RULE11]
    end
    return p[31:0];
  endfunction : mult

  function automatic dms_res_t accumulate(input logic [39:0] acc,
                                          input logic [31:0] prod,
                                          input logic sub,
                                          input logic rnd,
                                          input logic wide,
                                          input dms_mode_t m);
    logic [40:0] s;
    logic tie;
    dms_res_t r;
    // One guard bit above 40 exposes wide overflow
    s = sub ? {acc[39], acc} - {{9{prod[31]}}, prod}
            : {acc[39], acc} + {{9{prod[31]}}, prod}; // [RULE12] [RULE13]
    tie = s[15:0] == RND_TIE;
    if (rnd)
    begin
      s = (s + RND_HALF) & RND_MASK; // [RULE14]
      if (m.rounding_mode_bit && tie)
      begin
        s[RND_LSB] = 1'b0;
      end
    end
    r.ovf = wide ? s[40] != s[39]
                 : !(&s[40:NARROW_MSB] || ~|s[40:NARROW_MSB]); // [RULE15]
    r.value = s[39:0];
    if (r.ovf && m.accum_saturate_bit)
    begin
      if (wide)
      begin
        r.value = s[40] ? SAT40_NEG : SAT40_POS; // [RULE16]
      end
      else
      begin
        r.value = s[40] ? SAT32_NEG : SAT32_POS; // [RULE16]
      end
    end
    return r;
  endfunction : accumulate

  ////////////////////////////////////////////////////////////////////////////
  // State and registers
  dms_state_t state;
  dms_mode_t mode;
  dms_instr_t ir;
  logic [31:0] ir_word;
  logic [REP_W-1:0] repeat_count;
  logic [REP_W-1:0] rep_left;
  logic [15:0] coeff_pointer;
  logic [15:0] aux_pointer_three;
  logic [39:0] acc [4];
  logic illegal;
  logic [16:0] op_up_a;
  logic [16:0] op_up_b;
  logic [16:0] op_lo_a;
  logic [16:0] op_lo_b;
  logic [31:0] prod_up;
  logic [31:0] prod_lo;
  dms_res_t res_y;
  dms_res_t res_x;
  logic launch;
  logic bus_wr;
  logic bus_rd;
  logic next_fetch;
  logic last_pass;
  logic [15:0] ea;
  logic [15:0] next_ea;
  dms_instr_t next_ir;
  logic [15:0] data_step;
  logic [31:0] next_readdata;

  // Bus requests are served only while idle; a legal instruction write stalls
  assign launch = state == S_IDLE && avs_waitrequest && avs_write &&
    avs_address == REG_INSTR && legal(avs_writedata);
  assign bus_wr = state == S_IDLE && avs_waitrequest && avs_write && !launch;
  assign bus_rd = state == S_IDLE && avs_waitrequest && avs_read;
  assign last_pass = state == S_COMMIT && rep_left == '0;
  assign next_fetch = launch || (state == S_COMMIT && rep_left != '0);

  // Effective location of the data operand and its post-modify step
  assign ea = ir.indirect ? aux_pointer_three : {9'h000, ir.doff};
  assign data_step = ir.long_form ? STEP_PAIR : STEP_WORD; // [RULE21] [RULE22]

  // Fields of the word being written, used on the launch edge only
  assign next_ir = decode(avs_writedata);
  assign next_ea = next_ir.indirect ? aux_pointer_three
    : {9'h000, next_ir.doff};

  // Products and results from the registered, widened operands
  assign prod_up = mult(op_up_a, op_up_b, mode);
  assign prod_lo = mult(op_lo_a, op_lo_b, mode);
  assign res_y = accumulate(acc[ir.accum_y], prod_up, 1'b1, ir.round,
    mode.wide_overflow_mode_bit | ir.force40, mode); // [RULE3] [RULE17]
  assign res_x = accumulate(acc[ir.accum_x], prod_lo, 1'b0, ir.round,
    mode.wide_overflow_mode_bit | ir.force40, mode); // [RULE3] [RULE17]

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: fetch, multiply, commit, then repeat or finish
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= S_IDLE;
      rep_left <= '0;
      ir_word <= '0;
      ir <= '0;
    end
    else
    begin
      case (state)
        S_IDLE:
        begin
          if (launch)
          begin
            state <= S_FETCH;
            ir_word <= avs_writedata;
            ir <= next_ir;
            rep_left <= repeat_count; // [RULE19]
          end
        end
        S_FETCH: state <= S_MUL;
        S_MUL: state <= S_COMMIT;
        S_COMMIT:
        begin
          if (rep_left != '0)
          begin
            state <= S_FETCH; // [RULE19]
            rep_left <= rep_left - 1'b1;
          end
          else
          begin
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Memory addresses registered ahead of each fetch cycle
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mem_addr <= '0;
    end
    else
    begin
      mem_addr.data_rd <= next_fetch;
      mem_addr.coeff_rd <= next_fetch;
      mem_addr.data_pair_rd <= next_fetch &&
        (launch ? next_ir.long_form : ir.long_form);
      if (launch)
      begin
        mem_addr.data_addr <= next_ea; // [RULE7]
        mem_addr.data_pair_addr <= pair(next_ea); // [RULE8]
      end
      else if (next_fetch)
      begin
        mem_addr.data_addr <= ea; // [RULE7]
        mem_addr.data_pair_addr <= pair(ea); // [RULE8]
      end
      if (next_fetch)
      begin
        mem_addr.coeff_address_bus <= coeff_pointer; // [RULE5]
        mem_addr.coeff_pair_addr <= pair(coeff_pointer); // [RULE6]
      end
    end
  end

  // Pointers: software loads while idle, post-modify leaves fetch
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      coeff_pointer <= '0;
      aux_pointer_three <= '0;
    end
    else if (bus_wr && avs_address == REG_CPTR)
    begin
      coeff_pointer <= avs_writedata[15:0];
    end
    else if (bus_wr && avs_address == REG_APTR)
    begin
      aux_pointer_three <= avs_writedata[15:0];
    end
    else if (state == S_FETCH)
    begin
      if (ir.cmod == PMOD_INC)
      begin
        coeff_pointer <= coeff_pointer + STEP_PAIR; // [RULE20]
      end
      else if (ir.cmod == PMOD_DEC)
      begin
        coeff_pointer <= coeff_pointer - STEP_PAIR;
      end
      if (ir.indirect && ir.amod == PMOD_INC)
      begin
        aux_pointer_three <= aux_pointer_three + data_step;
      end
      else if (ir.indirect && ir.amod == PMOD_DEC)
      begin
        aux_pointer_three <= aux_pointer_three - data_step; // [RULE21] [RULE22]
      end
    end
  end

  // Operand capture; read data is valid the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      op_up_a <= '0;
      op_up_b <= '0;
      op_lo_a <= '0;
      op_lo_b <= '0;
    end
    else if (state == S_MUL)
    begin
      op_up_a <= ext17(ir.long_form ? rdbus.operand_c_bus
        : rdbus.operand_d_bus, ir.data_uns); // [RULE4] [RULE7] [RULE9]
      op_lo_a <= ext17(rdbus.operand_d_bus, ir.data_uns); // [RULE4] [RULE8]
      op_up_b <= ext17(rdbus.coeff_high_bus, ir.coeff_uns); // [RULE5]
      op_lo_b <= ext17(rdbus.coeff_low_bus, ir.coeff_uns); // [RULE6]
    end
  end

  // Accumulators and flags; both results land on one edge
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < 4; i++)
      begin
        acc[i] <= '0;
      end
      ovf_flags <= '0;
    end
    else if (state == S_COMMIT)
    begin
      // Same register on both sides: the lower unit's result wins
      acc[ir.accum_y] <= res_y.value; // [RULE23]
      acc[ir.accum_x] <= res_x.value; // [RULE23]
      ovf_flags[ir.accum_y] <= ovf_flags[ir.accum_y] | res_y.ovf; // [RULE15]
      ovf_flags[ir.accum_x] <= ovf_flags[ir.accum_x] | res_x.ovf; // [RULE15]
    end
    else if (bus_wr && avs_address >= REG_ACC_BASE)
    begin
      if (avs_address[0])
      begin
        acc[avs_address[2:1]][39:32] <= avs_writedata[7:0];
      end
      else
      begin
        acc[avs_address[2:1]][31:0] <= avs_writedata;
      end
    end
    else if (bus_wr && avs_address == REG_STATUS)
    begin
      ovf_flags <= ovf_flags & ~avs_writedata[3:0];
    end
  end

  // Mode, repeat count and illegal-opcode flag
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mode <= '0;
      repeat_count <= '0;
      illegal <= 1'b0;
    end
    else
    begin
      if (bus_wr && avs_address == REG_MODE)
      begin
        mode <= dms_mode_t'(avs_writedata[4:0]);
      end
      if (bus_wr && avs_address == REG_REPEAT)
      begin
        repeat_count <= avs_writedata[REP_W-1:0];
      end
      // A fresh illegal opcode outranks a clear in the same cycle
      if (bus_wr && avs_address == REG_INSTR)
      begin
        illegal <= 1'b1;
      end
      else if (bus_wr && avs_address == REG_STATUS &&
               avs_writedata[STAT_ILLEGAL])
      begin
        illegal <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read decode; unmapped words read zero
  always_comb
  begin
    next_readdata = '0;
    if (avs_address >= REG_ACC_BASE)
    begin
      if (avs_address[0])
      begin
        next_readdata[7:0] = acc[avs_address[2:1]][39:32];
      end
      else
      begin
        next_readdata = acc[avs_address[2:1]][31:0];
      end
    end
    else if (avs_address == REG_MODE)
    begin
      next_readdata[4:0] = mode;
    end
    else if (avs_address == REG_INSTR)
    begin
      next_readdata = ir_word;
    end
    else if (avs_address == REG_REPEAT)
    begin
      next_readdata[REP_W-1:0] = repeat_count;
    end
    else if (avs_address == REG_STATUS)
    begin
      next_readdata[3:0] = ovf_flags;
      next_readdata[STAT_ILLEGAL] = illegal;
      next_readdata[STAT_BUSY] = state != S_IDLE;
    end
    else if (avs_address == REG_CPTR)
    begin
      next_readdata[15:0] = coeff_pointer;
    end
    else if (avs_address == REG_APTR)
    begin
      next_readdata[15:0] = aux_pointer_three;
    end
  end

  // Answer one cycle after a plain access, or after the last commit
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end
    else if (!avs_waitrequest)
    begin
      avs_waitrequest <= 1'b1;
    end
    else if (last_pass || bus_wr)
    begin
      avs_waitrequest <= 1'b0;
    end
    else if (bus_rd)
    begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= next_readdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_launch;
    @(posedge ref_clk) disable iff (!rst_b)
    launch |=> state == S_FETCH && mem_addr.data_rd && mem_addr.coeff_rd;
  endproperty
  a_launch: assert property (p_launch) // [RULE1] [RULE2]
    else $error("legal opcode did not start a fetch");

  property p_pass;
    @(posedge ref_clk) disable iff (!rst_b)
    state == S_FETCH |=> state == S_MUL ##1 state == S_COMMIT;
  endproperty
  a_pass: assert property (p_pass) // [RULE3]
    else $error("pass did not finish in three cycles");

  property p_shared;
    @(posedge ref_clk) disable iff (!rst_b)
    state == S_COMMIT && !ir.long_form |-> op_up_a == op_lo_a;
  endproperty
  a_shared: assert property (p_shared) // [RULE4]
    else $error("shared word differs between multipliers");

  property p_long_high;
    @(posedge ref_clk) disable iff (!rst_b)
    state == S_MUL && ir.long_form |=>
      op_up_a[15:0] == $past(rdbus.operand_c_bus);
  endproperty
  a_long_high: assert property (p_long_high) // [RULE7]
    else $error("upper unit did not take the high operand");

  property p_pair;
    @(posedge ref_clk) disable iff (!rst_b)
    state == S_FETCH |->
      mem_addr.coeff_pair_addr[0] != mem_addr.coeff_address_bus[0] &&
      mem_addr.coeff_pair_addr[15:1] == mem_addr.coeff_address_bus[15:1];
  endproperty
  a_pair: assert property (p_pair) // [RULE6]
    else $error("coefficient pair address wrong");

  property p_cptr_inc;
    @(posedge ref_clk) disable iff (!rst_b)
    state == S_FETCH && ir.cmod == PMOD_INC |=>
      coeff_pointer == $past(coeff_pointer) + STEP_PAIR;
  endproperty
  a_cptr_inc: assert property (p_cptr_inc) // [RULE20]
    else $error("coefficient pointer did not advance by two");

  property p_aptr_dec;
    @(posedge ref_clk) disable iff (!rst_b)
    state == S_FETCH && ir.indirect && ir.amod == PMOD_DEC |=>
      aux_pointer_three == $past(aux_pointer_three) -
        (ir.long_form ? STEP_PAIR : STEP_WORD);
  endproperty
  a_aptr_dec: assert property (p_aptr_dec) // [RULE21] [RULE22]
    else $error("data pointer decrement step wrong");

  property p_unsigned;
    @(posedge ref_clk) disable iff (!rst_b)
    state == S_COMMIT && ir.data_uns |-> !op_up_a[16] && !op_lo_a[16];
  endproperty
  a_unsigned: assert property (p_unsigned) // [RULE9]
    else $error("unsigned operand was sign extended");

  property p_sub;
    @(posedge ref_clk) disable iff (!rst_b)
    state == S_COMMIT && !ir.round && !res_y.ovf |->
      res_y.value == acc[ir.accum_y] - {{8{prod_up[31]}}, prod_up};
  endproperty
  a_sub: assert property (p_sub) // [RULE12]
    else $error("upper result is not a subtraction");

  property p_commit;
    @(posedge ref_clk) disable iff (!rst_b)
    state == S_COMMIT && ir.accum_x != ir.accum_y |=>
      acc[ir.accum_x] == $past(res_x.value) &&
      acc[ir.accum_y] == $past(res_y.value);
  endproperty
  a_commit: assert property (p_commit) // [RULE23]
    else $error("results not committed together");

  property p_flags_hold;
    @(posedge ref_clk) disable iff (!rst_b)
    state == S_FETCH || state == S_MUL |=> $stable(ovf_flags);
  endproperty
  a_flags_hold: assert property (p_flags_hold) // [RULE23]
    else $error("overflow flag changed outside commit");

endmodule : dms_datapath

`default_nettype wire

// [verif/dms_mem_model.sv]
/*
  Read model of the operand and coefficient memories behind the datapath.
  Assumes the bench preloads mem and the block strobes one pass at a time.
*/
`timescale 1ns/1ns
`default_nettype none
module dms_mem_model
  import dms_pkg::*;
(
  input wire logic ref_clk,
  input wire dms_pkg::dms_addr_t m,
  output dms_pkg::dms_rdbus_t rdbus
);
  import dms_pkg::*;
  // Internal words only, coefficients included
  logic [15:0] mem [0:256-1];
  initial rdbus = '0;
  // Data one cycle after strobe; idle lanes toggle so stale data never passes
  always @(posedge ref_clk)
  begin
    rdbus.operand_c_bus <= m.data_rd ? mem[m.data_addr[7:0]]
      : ~rdbus.operand_c_bus;
    rdbus.operand_d_bus <= m.data_pair_rd ? mem[m.data_pair_addr[7:0]]
      : m.data_rd ? mem[m.data_addr[7:0]] : ~rdbus.operand_d_bus;
    rdbus.coeff_high_bus <= m.coeff_rd ? mem[m.coeff_address_bus[7:0]]
      : ~rdbus.coeff_high_bus;
    rdbus.coeff_low_bus <= m.coeff_rd ? mem[m.coeff_pair_addr[7:0]]
      : ~rdbus.coeff_low_bus;
  end
endmodule : dms_mem_model
`default_nettype wire

// [verif/tb_top.sv]
/*
  Self-checking bench: random dual multiply passes against a bench model.
  Assumes dms_datapath, dms_mem_model and one 125 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
  err_count++; $display("BAD %s exp %h got %h", n, e, s); end end
module tb_top;
  import dms_pkg::*;
  logic ref_clk = 0, rst_b = 0, avs_read = 0, avs_write = 0;
  logic [3:0] avs_address = '0, ovf_flags, fl;
  logic [31:0] avs_writedata = '0, avs_readdata, rd, seed = 85, op;
  logic avs_waitrequest;
  dms_rdbus_t rdbus;
  dms_addr_t mem_addr;
  logic [39:0] acc [4];
  logic [4:0] md;
  logic [15:0] cp, ap;
  logic [1:0] x, y;
  int err_count, total_checks, r;
  dms_datapath dut (.ref_clk, .rst_b, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .rdbus, .mem_addr,
    .ovf_flags);
  dms_mem_model mem_i (.ref_clk(ref_clk), .m(mem_addr), .rdbus(rdbus));
  always #4 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Expected result of one multiplier lane: {overflow, accumulator}
  function automatic logic [40:0] mac(logic [39:0] a, logic [15:0] d, c,
      logic du, cu, sub, rn, w);
    logic signed [33:0] p;
    logic [31:0] q;
    logic [40:0] s;
    logic o;
    p = $signed({~du & d[15], d}) * $signed({~cu & c[15], c});
    q = md[0] ? {p[30:0], 1'b0} : p[31:0];
    if (&md[1:0] && d == 16'h8000 && c == 16'h8000 && !du && !cu)
      q = 32'h7fff_ffff;
    s = {a[39], a} + (sub ? -{{9{q[31]}}, q} : {{9{q[31]}}, q});
    if (rn)
      s = (s + 41'h8000) & 41'h1ff_ffff_0000
        & ~{24'h0, md[2] && s[15:0] == 16'h8000, 16'h0};
    o = w ? s[40] != s[39] : !(s[40:31] == '0 || &s[40:31]);
    if (o && md[4])
      s[39:0] = w ? (s[40] ? 40'h80_0000_0000 : 40'h7f_ffff_ffff)
        : (s[40] ? 40'hff_8000_0000 : 40'h00_7fff_ffff);
    return {o, s[39:0]};
  endfunction : mac
  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
    @(posedge ref_clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    // Only the watchdog ends a wait that never sees an answer
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
  endtask : bus
  task automatic rdchk(logic [3:0] a, logic [31:0] e, string n);
    bus(0, a, 0);
    `CHK(n, e, rd)
  endtask : rdchk
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////
  // Watchdog: a few thousand cycles are expected
  initial
  begin
    #200000;
    err_count++;
    close_out();
  end
  // Main sequence; first passes are min*min fractional corners
  initial
  begin
    logic [40:0] hy, lx;
    logic [15:0] d, dl, st, ea;
    for (int i = 0; i < 256; i++)
      mem_i.mem[i] = 16'(rnd());
    fl = 0;
    cp = 16'(rnd());
    ap = 16'(rnd());
    repeat (20) @(posedge ref_clk);
    rst_b <= 1;
    rdchk(4'h3, 0, "status");
    bus(1, 4'h4, {16'h0, cp});
    bus(1, 4'h5, {16'h0, ap});
    for (int n = 0; n < 4; n++)
    begin
      acc[n] = {8'(rnd()), rnd()};
      bus(1, 4'(8 + 2 * n), acc[n][31:0]);
      bus(1, 4'(9 + 2 * n), {24'h0, acc[n][39:32]});
    end
    for (int i = 0; i < 40; i++)
    begin
      md = i < 4 ? 5'h03 : 5'(rnd());
      x = 2'(rnd());
      y = x + 2'(1 + rnd() % 3);
      r = rnd() % 2;
      op = {8'hfd, 5'h0, 2'(rnd() % 3), (i < 4 || rnd() % 2 == 1),
        rnd() & 1 ? 4'h5 : 4'h1, 2'h3, 2'(rnd() % 3), x, y,
        i < 4 ? 4'h0 : 4'(rnd())};
      if (i < 4)
        for (int k = 0; k < 2; k++)
        begin
          mem_i.mem[ap[7:0] ^ 8'(k)] = 16'h8000;
          mem_i.mem[cp[7:0] ^ 8'(k)] = 16'h8000;
        end
      bus(1, 4'h0, {27'h0, md});
      bus(1, 4'h2, r);
      bus(1, 4'h1, op);
      st = op[14] ? 16'h2 : 16'h1;
      repeat (r + 1)
      begin
        // Direct words sit at the low offset; indirect ones at the pointer
        ea = op[16] ? ap : {9'h0, op[23:17]};
        d = mem_i.mem[ea[7:0]];
        dl = op[14] ? mem_i.mem[ea[7:0] ^ 8'h1] : d;
        hy = mac(acc[y], d, mem_i.mem[cp[7:0]], op[3], op[2], 1'b1, op[0],
          md[3] | op[1]);
        lx = mac(acc[x], dl, mem_i.mem[cp[7:0] ^ 8'h1], op[3], op[2], 1'b0,
          op[0], md[3] | op[1]);
        acc[y] = hy[39:0];
        acc[x] = lx[39:0];
        fl[y] |= hy[40];
        fl[x] |= lx[40];
        cp += op[9:8] == 2'h1 ? 16'h2 : op[9:8] == 2'h2 ? -16'h2 : 16'h0;
        if (op[16])
          ap += op[18:17] == 2'h1 ? st : op[18:17] == 2'h2 ? -st : 16'h0;
      end
      rdchk(4'(8 + 2 * x), acc[x][31:0], "acc_x");
      rdchk(4'(9 + 2 * x), {24'h0, acc[x][39:32]}, "acc_x_hi");
      rdchk(4'(8 + 2 * y), acc[y][31:0], "acc_y");
      rdchk(4'(9 + 2 * y), {24'h0, acc[y][39:32]}, "acc_y_hi");
      rdchk(4'h4, {16'h0, cp}, "coeff_ptr");
      rdchk(4'h5, {16'h0, ap}, "aux_ptr");
      rdchk(4'h1, op, "instr");
      rdchk(4'h0, {27'h0, md}, "mode");
      `CHK("flags", fl, ovf_flags)
    end
    bus(1, 4'h1, 32'hfd01_3c00);
    rdchk(4'h3, {27'h1, fl}, "illegal");
    bus(1, 4'h3, 32'h1f);
    `CHK("flags_clr", 4'h0, ovf_flags)
    close_out();
  end
endmodule : tb_top
`default_nettype wire
